// [logic/sdpi_top.sv]
// sdram pin interface, command encoding, reset straps and clock outputs
`default_nettype none
module sdpi_top (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic [63:0]               mem_data_bus_i,
  input  wire sdpi_pkg::sdpi_dens_t      density,
  input  wire logic                      four_bank,
  input  wire sdpi_pkg::sdpi_cmd_t       cmd,
  input  wire logic [1:0]                cmd_rank,
  input  wire logic [1:0]                cmd_bank,
  input  wire logic [12:0]               cmd_row,
  input  wire logic [10:0]               cmd_col,
  input  wire logic [7:0]                byte_mask,
  input  wire logic [7:0]                aux_div,
  input  wire logic [7:0]                mclk_div,
  output logic                           system_reset_output_n,
  output logic                           hard_reset_pulse,
  output logic [40:0]                    strap_opts,
  output logic [1:0]                     mem_cs_n,
  output logic                           shared_select2_addr11,
  output logic                           shared_select3_addr12_bank1,
  output logic [10:0]                    mem_row_col_addr,
  output logic                           mem_bank0,
  output logic [1:0]                     mem_ras_n,
  output logic [1:0]                     mem_cas_n,
  output logic                           mem_write_enable_n,
  output logic [7:0]                     mem_dqm,
  output logic                           memory_clock_out,
  output logic                           programmable_aux_clock
);
  import sdpi_pkg::*;

  ////////////////////////////////////////////////////////////////
  // reset sequencing
  sdpi_rst_st_t st_r;
  logic [7:0]   hold_r;
  logic         first_r;

  // rst_n is taken as the buffered asynchronous reset input
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r   <= SDPI_ST_RESET;
      hold_r <= 8'h00;
    end else begin
      case (st_r)
        SDPI_ST_RESET: begin
          st_r   <= SDPI_ST_HOLD;
          hold_r <= RST_HOLD_CNT;
        end
        SDPI_ST_HOLD: begin
          if (hold_r == 8'h01) begin
            st_r <= SDPI_ST_RUN;
          end
          hold_r <= hold_r - 8'h01;
        end
        default: begin
          st_r <= SDPI_ST_RUN;
        end
      endcase
    end
  end

  // first clock after release: pulse and strap capture
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hard_reset_pulse <= 1'b0;
      first_r          <= 1'b1;
    end else begin
      hard_reset_pulse <= first_r;
      first_r          <= 1'b0;
    end
  end

  // straps caught at release, never touched again until reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_opts <= STRAP_RST;
    end else if (first_r) begin
      strap_opts <= mem_data_bus_i[40:0];
    end
  end

  // system parts stay in reset through the stretch
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      system_reset_output_n <= 1'b0;
    end else begin
      system_reset_output_n <= (st_r == SDPI_ST_RUN);
    end
  end

  ////////////////////////////////////////////////////////////////
  // command encoding: {cs, ras, cas, we} per standard table
  logic       ras_c;
  logic       cas_c;
  logic       we_c;
  logic       act_c;
  logic [1:0] cs_c;
  always_comb begin
    act_c = 1'b1;
    ras_c = 1'b1;
    cas_c = 1'b1;
    we_c  = 1'b1;
    case (cmd)
      SDPI_CMD_ACT: ras_c = 1'b0;
      SDPI_CMD_RD: cas_c = 1'b0;
      SDPI_CMD_WR: begin
        cas_c = 1'b0;
        we_c  = 1'b0;
      end
      SDPI_CMD_PRE: begin
        ras_c = 1'b0;
        we_c  = 1'b0;
      end
      SDPI_CMD_REF: begin
        ras_c = 1'b0;
        cas_c = 1'b0;
      end
      SDPI_CMD_MRS: begin
        ras_c = 1'b0;
        cas_c = 1'b0;
        we_c  = 1'b0;
      end
      SDPI_CMD_DESEL: act_c = 1'b0;
      default: act_c = 1'b1;
    endcase
    cs_c = 2'b11;
    if (act_c) begin
      cs_c[cmd_rank[0]] = 1'b0;
    end
  end

  // address mux: row for activate and mode register set, column otherwise
  logic [12:0] addr_c;
  always_comb begin
    addr_c = (cmd == SDPI_CMD_ACT || cmd == SDPI_CMD_MRS) ? cmd_row : {2'b00, cmd_col};
  end

  // pins registered; all held idle while rst_n is low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_cs_n                    <= 2'b11;
      mem_ras_n                   <= 2'b11;
      mem_cas_n                   <= 2'b11;
      mem_write_enable_n          <= 1'b1;
      mem_row_col_addr            <= 11'h000;
      mem_bank0                   <= 1'b0;
      shared_select2_addr11       <= 1'b1;
      shared_select3_addr12_bank1 <= 1'b1;
      mem_dqm                     <= 8'hff;
    end else begin
      mem_cs_n           <= cs_c;
      mem_ras_n          <= {2{ras_c}};
      mem_cas_n          <= {2{cas_c}};
      mem_write_enable_n <= we_c;
      mem_row_col_addr   <= addr_c[10:0];
      mem_bank0          <= cmd_bank[0];
      mem_dqm            <= byte_mask;
      if (density == SDPI_DENS_16M) begin
        shared_select2_addr11       <= ~(act_c && cmd_rank == 2'h2);
        shared_select3_addr12_bank1 <= ~(act_c && cmd_rank == 2'h3);
        if (act_c && cmd_rank[1]) begin
          mem_cs_n <= 2'b11;
        end
      end else begin
        shared_select2_addr11 <= addr_c[11];
        shared_select3_addr12_bank1 <= four_bank ? cmd_bank[1] : addr_c[12];
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // clock outputs from the synthesized core clock
  // real synthesizer is analog; this divider stands in for it
  sdpi_clkdiv u_mclk (
    .clk         (clk),
    .rst_n       (rst_n),
    .half_period (mclk_div),
    .clk_out     (memory_clock_out)
  );
  sdpi_clkdiv u_aux (
    .clk         (clk),
    .rst_n       (rst_n),
    .half_period (aux_div),
    .clk_out     (programmable_aux_clock)
  );

  ////////////////////////////////////////////////////////////////
  a_strap_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !first_r |=> $stable(strap_opts)) else $error("straps changed after capture");
  a_strap_take: assert property (@(posedge clk) disable iff (!rst_n)
    first_r |=> strap_opts == $past(mem_data_bus_i[40:0])) else $error("strap miss");
  a_rst_out_low: assert property (@(posedge clk) disable iff (!rst_n)
    hard_reset_pulse |-> !system_reset_output_n) else $error("reset out early");
  a_pulse_once: assert property (@(posedge clk) disable iff (!rst_n)
    hard_reset_pulse |=> !hard_reset_pulse) else $error("pulse too long");
  a_we_write: assert property (@(posedge clk) disable iff (!rst_n)
    cmd == SDPI_CMD_WR |=> !mem_write_enable_n && mem_cas_n == 2'b00) else $error("write enc");
  a_we_read: assert property (@(posedge clk) disable iff (!rst_n)
    cmd == SDPI_CMD_RD |=> mem_write_enable_n && mem_ras_n == 2'b11) else $error("read enc");
  a_desel_cs: assert property (@(posedge clk) disable iff (!rst_n)
    cmd == SDPI_CMD_DESEL |=> mem_cs_n == 2'b11) else $error("deselect drove cs");
  a_bank1_pin: assert property (@(posedge clk) disable iff (!rst_n)
    density != SDPI_DENS_16M && four_bank |=> shared_select3_addr12_bank1 == $past(cmd_bank[1]))
    else $error("bank1 pin wrong");
  a_col_addr: assert property (@(posedge clk) disable iff (!rst_n)
    cmd == SDPI_CMD_RD |=> mem_row_col_addr == $past(cmd_col)) else $error("column addr");

  // release steps: the one-cycle pulse, then the output held low a while
  sequence s_hard_pulse;
    hard_reset_pulse;
  endsequence
  sequence s_out_held;
    !system_reset_output_n [*8];
  endsequence
  a_rst_stretch: assert property (@(posedge clk) disable iff (!rst_n)
    s_hard_pulse |=> s_out_held) else $error("reset out released early");
  a_rst_release: assert property (@(posedge clk) disable iff (!rst_n)
    s_hard_pulse |-> ##[1:200] system_reset_output_n) else $error("reset out stuck low");
  a_nop_enc: assert property (@(posedge clk) disable iff (!rst_n)
    cmd == SDPI_CMD_NOP && !cmd_rank[1] |=> mem_cs_n != 2'b11 && mem_ras_n == 2'b11
      && mem_cas_n == 2'b11 && mem_write_enable_n) else $error("nop encoding");
  a_sel2_16m: assert property (@(posedge clk) disable iff (!rst_n)
    density == SDPI_DENS_16M && cmd != SDPI_CMD_DESEL && cmd_rank == 2'h2
    |=> !shared_select2_addr11 && mem_cs_n == 2'b11) else $error("select2 not driven");
endmodule
`default_nettype wire

// [common/sdpi_pkg.sv]
// constants and types for the sdram pin interface and reset straps
// Notes on behaviour
// - reset input is active-low, asynchronous
// - hard reset starts on reset rising edge
// - drive system reset output to other parts
// - clocks derive from crystal-referenced synthesizer; here sdpi_clkdiv divides clk instead
// - host clock between 25 and 100 MHz; CLK_HZ here is 125 MHz
// - programmable aux clock up to 135 MHz
// - memory clock defaults to 66 MHz; MCLK_DIV_RST of 0 gives clk/2, 62.5 MHz
// - shared pin: select2 or address bit 11
// - shared pin: select3, address 12, bank 1
// - row then column on eleven address lines
// - chip selects gate inputs except clock, cke, mask
// - sample data bits 40..0 at reset rise
// - two row, two column strobes, active low
// - write enable high read, low write
// - byte mask floats outputs, blocks write bytes
`default_nettype none
package sdpi_pkg;
  localparam int unsigned CLK_HZ         = 125000000;
  localparam int unsigned STRAP_W        = 41;
  localparam int unsigned MA_W           = 11;
  localparam int unsigned DQM_W          = 8;
  // hard reset stretch of the system reset output, in ns
  localparam int unsigned RST_HOLD_NS    = 1000;
  localparam int unsigned RST_HOLD_CYC   = (RST_HOLD_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam logic [7:0]  RST_HOLD_CNT   = 8'(RST_HOLD_CYC);
  localparam logic [40:0] STRAP_RST      = 41'h0;
  // aux and memory clock dividers: half period settings, and defaults
  localparam logic [7:0]  AUX_DIV_RST    = 8'h00;
  localparam logic [7:0]  MCLK_DIV_RST   = 8'h00;
  typedef enum logic [1:0] { SDPI_DENS_16M, SDPI_DENS_64M, SDPI_DENS_128M } sdpi_dens_t;
  typedef enum logic [2:0] {
    SDPI_CMD_NOP, SDPI_CMD_ACT, SDPI_CMD_RD, SDPI_CMD_WR,
    SDPI_CMD_PRE, SDPI_CMD_REF, SDPI_CMD_MRS, SDPI_CMD_DESEL
  } sdpi_cmd_t;
  typedef enum logic [1:0] { SDPI_ST_RESET, SDPI_ST_HOLD, SDPI_ST_RUN } sdpi_rst_st_t;
endpackage
`default_nettype wire

// [logic/sdpi_clkdiv.sv]
// divided clock output from the synthesizer reference
`default_nettype none
module sdpi_clkdiv (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] half_period,
  output logic            clk_out
);
  import sdpi_pkg::*;
  logic [7:0] cnt_r;
  ////////////////////////////////////////////////////////////////
  // toggle every half_period+1 cycles; zero gives clk/2
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r   <= 8'h00;
      clk_out <= 1'b0;
    end else if (cnt_r >= half_period) begin
      cnt_r   <= 8'h00;
      clk_out <= ~clk_out;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
endmodule
`default_nettype wire

// [dv/sdpi_mem_model.sv]
// far-side model: strap drivers on the data bus, sdram write lanes
`default_nettype none
module sdpi_mem_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [63:0] strap,
  input  wire logic [1:0]  mem_cs_n,
  input  wire logic [1:0]  mem_cas_n,
  input  wire logic        mem_write_enable_n,
  input  wire logic [7:0]  mem_dqm,
  output logic      [63:0] mem_data_bus,
  output logic      [7:0]  lanes
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0]  hold_r;
  logic [63:0] pat_r;
  // straps held two edges past release, then the bus churns
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) hold_r <= 2'h0;
    else if (hold_r != 2'h3) hold_r <= hold_r + 2'h1;
  end
  // churn between ~strap and strap, so a sample two edges late sees the inverted value
  always_ff @(posedge clk) begin
    pat_r <= (hold_r < 2'h2) ? ~strap : ~pat_r;
  end
  assign mem_data_bus = (hold_r < 2'h2) ? strap : pat_r;
  // masked lanes dropped; clock return is a board wire, unused here
  always_ff @(posedge clk) begin
    if (mem_cs_n != 2'h3 && mem_cas_n == 2'h0 && !mem_write_enable_n) begin
      lanes <= ~mem_dqm;
    end
  end
endmodule
`default_nettype wire

// [dv/tb_top.sv]
// bench for the sdram pin interface and reset straps
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sdpi_pkg::*;
  typedef struct packed {
    sdpi_cmd_t  c;
    sdpi_dens_t d;
    logic       f;
    logic [1:0] r, b;
    logic [12:0] a;
    logic [1:0] cs;
    logic [2:0] rcw;
    logic       ca, shc;
    logic [1:0] sh;
  } sdpi_row_t;
  logic        clk, rst_n, fb, s2, s3, sro_n, hp, mclk, aux, we_n, ba0;
  logic [63:0] md, strap;
  sdpi_dens_t  dens;
  sdpi_cmd_t   cmd;
  logic [1:0]  rk, bk, cs_n, ras_n, cas_n;
  logic [12:0] row;
  logic [10:0] ma;
  logic [7:0]  msk, adiv, mdiv, dqm, lanes;
  logic [40:0] so;
  int          n_errors, checked;
  sdpi_row_t   rows [12] = '{
    '{SDPI_CMD_NOP, SDPI_DENS_64M, 1'h0, 2'h0, 2'h0, 13'h0000, 2'h2, 3'h7, 1'h0, 1'h0, 2'h0},
    '{SDPI_CMD_ACT, SDPI_DENS_64M, 1'h0, 2'h0, 2'h1, 13'h1d55, 2'h2, 3'h3, 1'h1, 1'h1, 2'h3},
    '{SDPI_CMD_ACT, SDPI_DENS_64M, 1'h1, 2'h1, 2'h2, 13'h02aa, 2'h1, 3'h3, 1'h1, 1'h1, 2'h2},
    '{SDPI_CMD_ACT, SDPI_DENS_128M, 1'h1, 2'h0, 2'h1, 13'h1d55, 2'h2, 3'h3, 1'h1, 1'h1, 2'h1},
    '{SDPI_CMD_RD, SDPI_DENS_64M, 1'h0, 2'h1, 2'h0, 13'h07ff, 2'h1, 3'h5, 1'h1, 1'h0, 2'h0},
    '{SDPI_CMD_WR, SDPI_DENS_128M, 1'h0, 2'h0, 2'h0, 13'h0005, 2'h2, 3'h4, 1'h1, 1'h0, 2'h0},
    '{SDPI_CMD_PRE, SDPI_DENS_64M, 1'h0, 2'h0, 2'h0, 13'h0400, 2'h2, 3'h2, 1'h0, 1'h0, 2'h0},
    '{SDPI_CMD_REF, SDPI_DENS_64M, 1'h0, 2'h1, 2'h0, 13'h0000, 2'h1, 3'h1, 1'h0, 1'h0, 2'h0},
    '{SDPI_CMD_MRS, SDPI_DENS_64M, 1'h0, 2'h0, 2'h0, 13'h02aa, 2'h2, 3'h0, 1'h1, 1'h0, 2'h0},
    '{SDPI_CMD_DESEL, SDPI_DENS_64M, 1'h0, 2'h0, 2'h0, 13'h0000, 2'h3, 3'h7, 1'h0, 1'h0, 2'h0},
    '{SDPI_CMD_ACT, SDPI_DENS_16M, 1'h0, 2'h2, 2'h1, 13'h02aa, 2'h3, 3'h3, 1'h1, 1'h1, 2'h2},
    '{SDPI_CMD_ACT, SDPI_DENS_16M, 1'h0, 2'h3, 2'h0, 13'h02aa, 2'h3, 3'h3, 1'h1, 1'h1, 2'h1}};
  sdpi_top i_dut (.clk(clk), .rst_n(rst_n), .mem_data_bus_i(md), .density(dens),
    .four_bank(fb), .cmd(cmd), .cmd_rank(rk), .cmd_bank(bk), .cmd_row(row),
    .cmd_col(row[10:0]), .byte_mask(msk), .aux_div(adiv), .mclk_div(mdiv),
    .system_reset_output_n(sro_n), .hard_reset_pulse(hp), .strap_opts(so), .mem_cs_n(cs_n),
    .shared_select2_addr11(s2), .shared_select3_addr12_bank1(s3), .mem_row_col_addr(ma),
    .mem_bank0(ba0), .mem_ras_n(ras_n), .mem_cas_n(cas_n), .mem_write_enable_n(we_n),
    .mem_dqm(dqm), .memory_clock_out(mclk), .programmable_aux_clock(aux));
  sdpi_mem_model i_mem (.clk(clk), .rst_n(rst_n), .strap(strap), .mem_cs_n(cs_n),
    .mem_cas_n(cas_n), .mem_write_enable_n(we_n), .mem_dqm(dqm), .mem_data_bus(md),
    .lanes(lanes));
  ////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic test_done;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // release reset, wait for the hard reset pulse, check the straps
  task automatic rel;
    int k;
    @(negedge clk) rst_n = 1'h1;
    for (k = 0; k < 8 && hp !== 1'h1; k++) @(negedge clk);
    if (k == 8) begin
      n_errors++;
      test_done;
    end
    chk("straps", strap[40:0], so);
  endtask
  // rise-to-rise period of a divided clock, in clk cycles
  task automatic per(input bit s, input int e);
    logic p, v;
    int n, t;
    n = 0;
    t = 0;
    p = 1'h1;
    for (int j = 0; j < 99 && t < 2; j++) begin
      @(posedge clk);
      #1;
      v = s ? aux : mclk;
      n++;
      if (v === 1'h1 && p === 1'h0) begin
        t++;
        if (t == 1) n = 0;
      end
      p = v;
    end
    chk("period", 64'(e), 64'(n));
  endtask
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  initial begin
    n_errors = 0;
    checked = 0;
    {rst_n, fb, rk, bk, row} = '0;
    dens = SDPI_DENS_64M;
    cmd = SDPI_CMD_NOP;
    {msk, adiv, mdiv} = {8'h00, 8'h02, 8'h00};
    strap = 64'hfedc_ba98_7654_3210;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("rst out", 1'h0, sro_n);
    chk("cs idle", 2'h3, cs_n);
    chk("dqm idle", 8'hff, dqm);
    rel;
    repeat (100) @(negedge clk);
    chk("rst hold", 1'h0, sro_n);
    for (int k = 0; k < 60 && sro_n !== 1'h1; k++) @(negedge clk);
    chk("rst out", 1'h1, sro_n);
    foreach (rows[i]) begin
      cmd = rows[i].c;
      dens = rows[i].d;
      {fb, rk, bk, row} = {rows[i].f, rows[i].r, rows[i].b, rows[i].a};
      msk = 8'h5a ^ 8'(i);
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk("cs", rows[i].cs, cs_n);
      chk("dqm", msk, dqm);
      if (rows[i].c == SDPI_CMD_WR) chk("lanes", {56'h0, ~msk}, lanes);
      if (rows[i].c != SDPI_CMD_DESEL) begin
        chk("ras", {2{rows[i].rcw[2]}}, ras_n);
        chk("cas", {2{rows[i].rcw[1]}}, cas_n);
        chk("we", rows[i].rcw[0], we_n);
      end
      if (rows[i].ca) chk("addr", {rows[i].b[0], rows[i].a[10:0]}, {ba0, ma});
      if (rows[i].shc) chk("shared", rows[i].sh, {s3, s2});
    end
    per(1'h1, 6);
    per(1'h0, 2);
    @(negedge clk) rst_n = 1'h0;
    #1;
    chk("async rst", 3'h6, {cs_n, sro_n});
    strap = 64'h0123_4567_89ab_cdef;
    rel;
    repeat (20) @(negedge clk);
    chk("straps kept", strap[40:0], so);
    test_done;
  end
endmodule
`default_nettype wire
